// >>> rtl/cfgc_pkg.sv
package cfgc_pkg;
  // register indexes on the config port
  localparam logic [7:0] IDX_CTRL_2 = 8'hC2;
  localparam logic [7:0] IDX_CTRL_3 = 8'hC3;
  localparam logic [7:0] IDX_CTRL_4 = 8'hE8;
  localparam logic [7:0] IDX_CTRL_5 = 8'hE9;
  localparam logic [7:0] IDX_CTRL_6 = 8'hEA;
  // window always reachable while the map is closed
  localparam logic [7:0] IDX_OPEN_LO = 8'hC0;
  localparam logic [7:0] IDX_OPEN_HI = 8'hCF;
  localparam logic [7:0] IDX_OPEN_FE = 8'hFE;
  localparam logic [7:0] IDX_OPEN_FF = 8'hFF;
  localparam logic [3:0] MAP_UNLOCK  = 4'h1;
  // implemented (storage) bits per register
  localparam logic [7:0] MASK_CTRL_2 = 8'hFF;
  localparam logic [7:0] MASK_CTRL_3 = 8'hF7;
  localparam logic [7:0] MASK_CTRL_4 = 8'h87;
  localparam logic [7:0] MASK_CTRL_5 = 8'h21;
  localparam logic [7:0] MASK_CTRL_6 = 8'h43;
  // reset values
  localparam logic [7:0] RST_CTRL_2 = 8'h00;
  localparam logic [7:0] RST_CTRL_3 = 8'h00;
  localparam logic [7:0] RST_CTRL_4 = 8'h05;
  localparam logic [7:0] RST_CTRL_5 = 8'h00;
  localparam logic [7:0] RST_CTRL_6 = 8'h00;
  // config_ctrl_2 fields
  localparam int B2_PINS_EN   = 7;
  localparam int B2_LEGACY_WG = 4;
  localparam int B2_HALT_LP   = 3;
  localparam int B2_NW_FREEZE = 2;
  localparam int B2_IDLE_INS  = 1;
  // config_ctrl_3 fields
  localparam int B3_MAP_HI    = 7;
  localparam int B3_MAP_LO    = 4;
  localparam int B3_LIN_BURST = 2;
  localparam int B3_NEST_NMI  = 1;
  localparam int B3_FREEZE    = 0;
  // config_ctrl_4 fields
  localparam int B4_IDENT     = 7;
  localparam int B4_IO_RECOVERY_DELAY_HI   = 2;
  localparam int B4_IO_RECOVERY_DELAY_LO   = 0;
  localparam logic [2:0] IO_RECOVERY_DELAY_NONE = 3'h7;
  // config_ctrl_5 fields
  localparam int B5_REGION_EN = 5;
  localparam int B5_WR_ALLOC  = 0;
  // config_ctrl_6 fields
  localparam int B6_NEST_MGMT = 6;
  localparam int B6_R3_GUARD  = 1;
  localparam int B6_ENH_MGMT  = 0;
  // legacy area 640 KByte up to 1 MByte
  localparam logic [31:0] LEGACY_LO = 32'h000A_0000;
  localparam logic [31:0] LEGACY_HI = 32'h0010_0000;
  localparam int REGION3 = 3;
endpackage

// >>> rtl/cfgc_regs.sv
// Local design decisions: the placing of the registers and strobed register access.
module cfgc_regs #(
  parameter int REGIONS = 8
) (
  input  wire logic               clk,
  input  wire logic               srst,
  input  wire logic [7:0]         cfg_addr,
  input  wire logic [7:0]         cfg_wdata,
  input  wire logic               cfg_wr,
  input  wire logic               cfg_rd,
  output logic      [7:0]         cfg_rdata,
  input  wire logic               mgmt_active,
  input  wire logic               mgmt_entry,
  input  wire logic               mgmt_resume,
  input  wire logic               region3_mgmt_space,
  input  wire logic               region3_hit,
  input  wire logic               low_power_request_pin_n,
  output logic                    low_power_ack_pin_n_o,
  output logic                    low_power_ack_pin_oe,
  input  wire logic               halt_exec,
  input  wire logic               wake_event,
  output logic                    low_power_state,
  input  wire logic               acc_valid,
  input  wire logic               acc_write,
  input  wire logic               acc_cacheable,
  input  wire logic [31:0]        acc_addr,
  output logic                    write_blocked,
  output logic                    region3_is_mgmt,
  output logic                    no_writeback_locked,
  input  wire logic               burst_ready_seen,
  input  wire logic               addr_strobe_req,
  output logic                    bus_idle_slot,
  output logic                    addr_strobe_go,
  input  wire logic [1:0]         burst_start,
  input  wire logic [1:0]         burst_beat,
  output logic      [1:0]         burst_offset,
  output logic                    nmi_nest_ok,
  output logic                    mgmt_nest_ok,
  output logic                    mgmt_bits_locked,
  output logic                    enhanced_mgmt_mode,
  output logic                    ident_id_writable,
  input  wire logic               ident_exec,
  output logic                    ident_invalid_op,
  input  wire logic               io_access,
  output logic                    io_ready,
  output logic [REGIONS-1:0]      region_enable,
  input  wire logic               read_miss,
  input  wire logic               write_miss,
  output logic                    alloc_line
);

  ////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [7:0] c2;
    logic [7:0] c3;
    logic [7:0] c4;
    logic [7:0] c5;
    logic [7:0] c6;
    logic [7:0] rdata;
    logic       req_s1;
    logic       req_s2;
    logic       low_power_request_pin_pin;
    logic       low_power_request_pin_halt;
    logic [6:0] io_cnt;
    logic       idle_pend;
    logic       ads_hold;
  } cfgc_state_s;

  cfgc_state_s st;
  cfgc_state_s next_st;

  // io gap in clocks for a recovery code
  function automatic logic [6:0] io_gap(input logic [2:0] code);
    if (code == cfgc_pkg::IO_RECOVERY_DELAY_NONE) begin
      return 7'h00;
    end
    return 7'(8'h01 << code);
  endfunction

  // index reachable under current map setting
  function automatic logic idx_open(input logic [7:0] a, input logic [3:0] map);
    logic win;
    win = (a >= cfgc_pkg::IDX_OPEN_LO) && (a <= cfgc_pkg::IDX_OPEN_HI);
    return (map == cfgc_pkg::MAP_UNLOCK) || win ||
           (a == cfgc_pkg::IDX_OPEN_FE) || (a == cfgc_pkg::IDX_OPEN_FF);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // decode helpers
  logic       open_acc;
  logic       wr_c2;
  logic       wr_c3;
  logic       wr_c4;
  logic       wr_c5;
  logic       wr_c6;
  logic       frozen;
  logic       mgmt_wr_ok;
  logic [7:0] rd_val;
  logic       legacy_hit;
  logic       r3_active;

  // map gating shared by reads and writes
  assign open_acc = idx_open(cfg_addr, st.c3[cfgc_pkg::B3_MAP_HI:cfgc_pkg::B3_MAP_LO]);
  assign frozen     = st.c3[cfgc_pkg::B3_FREEZE];
  // locked bits only change from inside a handler
  assign mgmt_wr_ok = !frozen || mgmt_active;

  // address decode
  always_comb begin
    wr_c2 = 1'b0;
    wr_c3 = 1'b0;
    wr_c4 = 1'b0;
    wr_c5 = 1'b0;
    wr_c6 = 1'b0;
    rd_val = 8'h00; // unmapped or closed reads give zero
    if (!open_acc) begin
      rd_val = 8'h00;
    end else if (cfg_addr == cfgc_pkg::IDX_CTRL_2) begin
      wr_c2 = cfg_wr;
      rd_val = st.c2; // reserved bits read back stored
    end else if (cfg_addr == cfgc_pkg::IDX_CTRL_3) begin
      wr_c3 = cfg_wr;
      rd_val = st.c3;
    end else if (cfg_addr == cfgc_pkg::IDX_CTRL_4) begin
      wr_c4 = cfg_wr;
      rd_val = st.c4;
    end else if (cfg_addr == cfgc_pkg::IDX_CTRL_5) begin
      wr_c5 = cfg_wr;
      rd_val = st.c5;
    end else if (cfg_addr == cfgc_pkg::IDX_CTRL_6) begin
      wr_c6 = cfg_wr;
      rd_val = st.c6;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_st = st;
    // read data stand only in the cycle after the strobe
    next_st.rdata = cfg_rd ? rd_val : 8'h00;
    if (wr_c2) begin
      next_st.c2 = cfg_wdata & cfgc_pkg::MASK_CTRL_2;
    end
    if (wr_c3) begin
      next_st.c3[cfgc_pkg::B3_MAP_HI:cfgc_pkg::B3_MAP_LO] =
        cfg_wdata[cfgc_pkg::B3_MAP_HI:cfgc_pkg::B3_MAP_LO];
      next_st.c3[cfgc_pkg::B3_LIN_BURST] = cfg_wdata[cfgc_pkg::B3_LIN_BURST];
      if (mgmt_wr_ok) begin
        next_st.c3[cfgc_pkg::B3_NEST_NMI] = cfg_wdata[cfgc_pkg::B3_NEST_NMI];
      end
      // write of one sets, zero never clears
      next_st.c3[cfgc_pkg::B3_FREEZE] = frozen | cfg_wdata[cfgc_pkg::B3_FREEZE];
    end
    if (wr_c4) begin
      next_st.c4 = cfg_wdata & cfgc_pkg::MASK_CTRL_4;
    end
    if (wr_c5) begin
      next_st.c5 = cfg_wdata & cfgc_pkg::MASK_CTRL_5;
    end
    if (wr_c6) begin
      next_st.c6[cfgc_pkg::B6_R3_GUARD] = cfg_wdata[cfgc_pkg::B6_R3_GUARD];
      if (mgmt_wr_ok) begin
        next_st.c6[cfgc_pkg::B6_NEST_MGMT] = cfg_wdata[cfgc_pkg::B6_NEST_MGMT];
        next_st.c6[cfgc_pkg::B6_ENH_MGMT]  = cfg_wdata[cfgc_pkg::B6_ENH_MGMT];
      end
    end
    // hardware events win over software writes
    if (mgmt_entry) begin
      next_st.c6[cfgc_pkg::B6_NEST_MGMT] = 1'b0;
    end else if (mgmt_resume) begin
      next_st.c6[cfgc_pkg::B6_NEST_MGMT] = 1'b1;
    end
    // suspend request pin, two stage sync
    next_st.req_s1 = !low_power_request_pin_n;
    next_st.req_s2 = st.req_s1;
    // pin only honoured while enabled
    next_st.low_power_request_pin_pin = st.c2[cfgc_pkg::B2_PINS_EN] && st.req_s2;
    if (wake_event) begin
      next_st.low_power_request_pin_halt = 1'b0;
    end
    if (halt_exec && st.c2[cfgc_pkg::B2_HALT_LP]) begin
      next_st.low_power_request_pin_halt = 1'b1;
    end
    // io recovery spacing in bus clocks
    if (io_access) begin
      next_st.io_cnt = io_gap(st.c4[cfgc_pkg::B4_IO_RECOVERY_DELAY_HI:cfgc_pkg::B4_IO_RECOVERY_DELAY_LO]);
    end else if (st.io_cnt != 7'h00) begin
      next_st.io_cnt = st.io_cnt - 7'h01;
    end
    // idle slot one cycle after burst ready
    next_st.idle_pend = st.c2[cfgc_pkg::B2_IDLE_INS] && burst_ready_seen;
    next_st.ads_hold  = st.c2[cfgc_pkg::B2_IDLE_INS] && addr_strobe_req;
    if (srst) begin
      next_st = '0;
      next_st.c2 = cfgc_pkg::RST_CTRL_2;
      next_st.c3 = cfgc_pkg::RST_CTRL_3;
      next_st.c4 = cfgc_pkg::RST_CTRL_4;
      next_st.c5 = cfgc_pkg::RST_CTRL_5;
      next_st.c6 = cfgc_pkg::RST_CTRL_6;
    end
  end

  // single state register
  always_ff @(posedge clk) begin
    st <= next_st;
  end

  ////////////////////////////////////////////////////////////////////
  // outputs
  assign cfg_rdata = st.rdata;

  // ack low while suspended, floats when pins off
  assign low_power_ack_pin_oe  = st.c2[cfgc_pkg::B2_PINS_EN];
  assign low_power_ack_pin_n_o = !(st.low_power_request_pin_pin || st.low_power_request_pin_halt);
  assign low_power_state       = st.low_power_request_pin_pin || st.low_power_request_pin_halt;

  // region enables; region3 forced on in mgmt space
  always_comb begin
    region_enable = {REGIONS{st.c5[cfgc_pkg::B5_REGION_EN]}};
    if (region3_mgmt_space) begin
      region_enable[cfgc_pkg::REGION3] = 1'b1;
    end
  end
  assign r3_active       = region_enable[cfgc_pkg::REGION3] && region3_hit;
  assign region3_is_mgmt = r3_active && region3_mgmt_space;

  // write protection checks
  assign legacy_hit = (acc_addr >= cfgc_pkg::LEGACY_LO) && (acc_addr < cfgc_pkg::LEGACY_HI);
  assign write_blocked = acc_valid && acc_write &&
    ((st.c2[cfgc_pkg::B2_LEGACY_WG] && acc_cacheable && legacy_hit) ||
     (st.c6[cfgc_pkg::B6_R3_GUARD] && r3_active && !mgmt_active));

  assign no_writeback_locked = st.c2[cfgc_pkg::B2_NW_FREEZE];

  // idle insertion delays the strobe by one cycle
  assign bus_idle_slot  = st.idle_pend;
  assign addr_strobe_go = st.c2[cfgc_pkg::B2_IDLE_INS] ? st.ads_hold : addr_strobe_req;

  // linear adds, 1+4 interleave xors
  assign burst_offset = st.c3[cfgc_pkg::B3_LIN_BURST] ? 2'(burst_start + burst_beat)
                                                     : (burst_start ^ burst_beat);

  // nesting permissions
  assign nmi_nest_ok        = st.c3[cfgc_pkg::B3_NEST_NMI] && mgmt_active;
  assign enhanced_mgmt_mode = st.c6[cfgc_pkg::B6_ENH_MGMT];
  assign mgmt_nest_ok       = st.c6[cfgc_pkg::B6_ENH_MGMT] && st.c6[cfgc_pkg::B6_NEST_MGMT];
  assign mgmt_bits_locked   = frozen && !mgmt_active;

  // identification instruction gate
  assign ident_id_writable = st.c4[cfgc_pkg::B4_IDENT];
  assign ident_invalid_op  = ident_exec && !st.c4[cfgc_pkg::B4_IDENT];

  assign io_ready   = (st.io_cnt == 7'h00);
  assign alloc_line = read_miss || (write_miss && st.c5[cfgc_pkg::B5_WR_ALLOC]);

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  AST_FREEZE_STICKY: assert property (frozen |=> frozen)
    else $error("freeze bit dropped");

  AST_NEST_ENTRY: assert property (mgmt_entry |=> !st.c6[cfgc_pkg::B6_NEST_MGMT])
    else $error("nest bit not cleared on entry");

  AST_NEST_RESUME: assert property (mgmt_resume && !mgmt_entry |=> st.c6[cfgc_pkg::B6_NEST_MGMT])
    else $error("nest bit not set on resume");

  AST_IO_CODE0: assert property ((io_access && st.c4[2:0] == 3'h0) ##1 !io_access
                                |-> !io_ready ##1 io_ready)
    else $error("io gap wrong for code 0");

  AST_IO_CODE5: assert property ((io_access && st.c4[2:0] == 3'h5) |=> !io_ready[*8])
    else $error("io gap too short for code 5");

  AST_IO_RECOVERY_DELAY_RESET: assert property ($past(srst) |-> st.c4 == 8'h05)
    else $error("io recovery reset value wrong");

  AST_MAP_CLOSED: assert property (cfg_rd && cfg_addr == 8'hE8 && st.c3[7:4] != 4'h1
                                  |=> cfg_rdata == 8'h00)
    else $error("closed index readable");

  AST_LEGACY_GUARD: assert property (acc_valid && acc_write && acc_cacheable
                                    && st.c2[4] && acc_addr == 32'h000A_0000 |-> write_blocked)
    else $error("legacy area write not blocked");

  AST_REGION3_ON: assert property (region3_mgmt_space |-> region_enable[3])
    else $error("region3 not kept active");

  AST_HALT_SUSPEND: assert property (halt_exec && st.c2[3] |=> low_power_state)
    else $error("halt did not suspend");

  AST_ACK_FLOAT: assert property (!st.c2[7] |-> !low_power_ack_pin_oe ##1 !st.low_power_request_pin_pin)
    else $error("ack driven while pins disabled");

  AST_MGMT_FREEZE: assert property (cfg_wr && cfg_addr == 8'hEA && frozen && !mgmt_active
                                   && !mgmt_entry && !mgmt_resume
                                   |=> st.c6[0] == $past(st.c6[0]))
    else $error("locked mode bit changed");

  COV_UNLOCK: cover property (wr_c3 && cfg_wdata[7:4] == 4'h1 ##1 wr_c4);
  COV_FREEZE: cover property (wr_c3 && cfg_wdata[0] ##1 frozen);
  COV_SUSPEND: cover property (halt_exec && st.c2[3] ##1 low_power_state ##[1:20] !low_power_state);
  COV_IO_GAP: cover property (io_access ##1 !io_ready[*4] ##1 io_ready);

endmodule

// >>> verification/tb_cpu_config_control_regs.sv
module tb_cpu_config_control_regs;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, srst, cfg_wr, cfg_rd, mgmt_active, region3_mgmt_space, region3_hit;
  logic        low_power_request_pin_n, acc_valid, acc_write, acc_cacheable, ident_exec;
  logic        read_miss, write_miss;
  logic [7:0]  cfg_addr, cfg_wdata, cfg_rdata;
  logic [31:0] acc_addr;
  logic [1:0]  burst_start, burst_beat, burst_offset;
  logic [6:0]  pl;
  logic        low_power_ack_pin_n_o, low_power_ack_pin_oe, low_power_state, write_blocked;
  logic        region3_is_mgmt, no_writeback_locked, bus_idle_slot, addr_strobe_go, nmi_nest_ok;
  logic        mgmt_nest_ok, mgmt_bits_locked, enhanced_mgmt_mode, ident_id_writable;
  logic        ident_invalid_op, io_ready, alloc_line;
  logic [7:0]  region_enable;
  int          n_errors;
  int          checked;

  cfgc_regs #(.REGIONS(8)) uut (
    .clk(clk), .srst(srst), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata), .mgmt_active(mgmt_active), .mgmt_entry(pl[2]),
    .mgmt_resume(pl[3]), .region3_mgmt_space(region3_mgmt_space), .region3_hit(region3_hit),
    .low_power_request_pin_n(low_power_request_pin_n), .low_power_ack_pin_n_o(low_power_ack_pin_n_o),
    .low_power_ack_pin_oe(low_power_ack_pin_oe), .halt_exec(pl[0]), .wake_event(pl[1]),
    .low_power_state(low_power_state), .acc_valid(acc_valid), .acc_write(acc_write),
    .acc_cacheable(acc_cacheable), .acc_addr(acc_addr), .write_blocked(write_blocked),
    .region3_is_mgmt(region3_is_mgmt), .no_writeback_locked(no_writeback_locked),
    .burst_ready_seen(pl[5]), .addr_strobe_req(pl[6]), .bus_idle_slot(bus_idle_slot),
    .addr_strobe_go(addr_strobe_go), .burst_start(burst_start), .burst_beat(burst_beat),
    .burst_offset(burst_offset), .nmi_nest_ok(nmi_nest_ok), .mgmt_nest_ok(mgmt_nest_ok),
    .mgmt_bits_locked(mgmt_bits_locked), .enhanced_mgmt_mode(enhanced_mgmt_mode),
    .ident_id_writable(ident_id_writable), .ident_exec(ident_exec), .ident_invalid_op(ident_invalid_op),
    .io_access(pl[4]), .io_ready(io_ready), .region_enable(region_enable), .read_miss(read_miss),
    .write_miss(write_miss), .alloc_line(alloc_line)
  );

  //////////////////////////////////////////////////////////////////////////////
  // free running core clock, 8 ns
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // four-state compare, so an unknown matches only an unknown
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("errors=%0d checked=%0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    cfg_addr <= a;
    cfg_wdata <= d;
    cfg_wr <= 1'b1;
    @(posedge clk);
    cfg_wr <= 1'b0;
    // let the taken write settle before callers look at outputs
    #1;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    cfg_addr <= a;
    cfg_rd <= 1'b1;
    @(posedge clk);
    cfg_rd <= 1'b0;
    #1;
    chk(cfg_rdata, e);
  endtask

  // one-cycle pulse; returns just after the edge that took it
  task automatic pulse(input int i);
    @(posedge clk);
    pl[i] <= 1'b1;
    @(posedge clk);
    pl[i] <= 1'b0;
    #1;
  endtask

  task automatic do_reset();
    @(posedge clk);
    srst <= 1'b1;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // watchdog: whole sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_errors = n_errors + 1;
    end_of_test();
  end

  // main sequence
  initial begin
    logic [7:0]  idx [4];
    logic [7:0]  msk [4];
    logic [31:0] la [4];
    int          n;
    idx = '{cfgc_pkg::IDX_CTRL_2, cfgc_pkg::IDX_CTRL_4, cfgc_pkg::IDX_CTRL_5, cfgc_pkg::IDX_CTRL_6};
    msk = '{8'hFF, 8'h87, 8'h21, 8'h43};
    la = '{32'h000A_0000, 32'h000F_FFFF, 32'h0010_0000, 32'h0009_FFFF};
    n_errors = 0;
    checked = 0;
    {cfg_wr, cfg_rd, mgmt_active, region3_mgmt_space, region3_hit, ident_exec} = 6'h00;
    {acc_valid, acc_write, acc_cacheable, read_miss, write_miss} = 5'h00;
    {cfg_addr, cfg_wdata, acc_addr, burst_start, burst_beat, pl} = '0;
    low_power_request_pin_n = 1'b1;
    srst = 1'b1;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    // reset values and the closed map
    rd(cfgc_pkg::IDX_CTRL_2, 8'h00);
    rd(cfgc_pkg::IDX_CTRL_4, 8'h00);
    chk(io_ready, 1'b1);
    wr(cfgc_pkg::IDX_CTRL_3, 8'h10);
    rd(cfgc_pkg::IDX_CTRL_4, 8'h05);
    rd(cfgc_pkg::IDX_CTRL_5, 8'h00);
    rd(cfgc_pkg::IDX_CTRL_6, 8'h00);
    rd(8'h50, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(idx[i], 8'hFF);
      rd(idx[i], msk[i]);
    end
    wr(cfgc_pkg::IDX_CTRL_3, 8'h1E);
    rd(cfgc_pkg::IDX_CTRL_3, 8'h16);
    // everything but freeze enabled: outputs follow the bits
    @(posedge clk);
    {read_miss, write_miss, ident_exec, burst_start, burst_beat} <= {3'b011, 2'h1, 2'h3};
    #1;
    chk(low_power_ack_pin_oe, 1'b1);
    chk(no_writeback_locked, 1'b1);
    chk(enhanced_mgmt_mode, 1'b1);
    chk({ident_id_writable, ident_invalid_op}, 2'b10);
    chk(mgmt_nest_ok, 1'b1);
    chk(region_enable, 8'hFF);
    chk(alloc_line, 1'b1);
    chk(burst_offset, 2'h0);
    chk(nmi_nest_ok, 1'b0);
    @(posedge clk);
    mgmt_active <= 1'b1;
    #1;
    chk(nmi_nest_ok, 1'b1);
    mgmt_active <= 1'b0;
    pulse(0);
    chk(low_power_state, 1'b1);
    pulse(1);
    chk(low_power_state, 1'b0);
    pulse(5);
    chk(bus_idle_slot, 1'b1);
    pulse(6);
    chk(addr_strobe_go, 1'b1);
    // config_ctrl_2 and config_ctrl_3 off, map still open
    wr(cfgc_pkg::IDX_CTRL_2, 8'h00);
    wr(cfgc_pkg::IDX_CTRL_3, 8'h10);
    #1;
    chk({low_power_ack_pin_oe, no_writeback_locked, burst_offset}, 4'h2);
    pulse(5);
    chk(bus_idle_slot, 1'b0);
    pulse(0);
    chk(low_power_state, 1'b0);
    @(posedge clk);
    pl[6] <= 1'b1;
    #1;
    chk(addr_strobe_go, 1'b1);
    @(posedge clk);
    pl[6] <= 1'b0;
    // legacy area guard on cacheable writes
    wr(cfgc_pkg::IDX_CTRL_2, 8'h10);
    @(posedge clk);
    {acc_valid, acc_write, acc_cacheable} <= 3'b111;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      acc_addr <= la[i];
      #1;
      chk(write_blocked, i < 2);
    end
    // io recovery codes, ident disabled
    for (int c = 0; c < 8; c++) begin
      wr(cfgc_pkg::IDX_CTRL_4, 8'(c));
      pulse(4);
      n = 0;
      while (io_ready !== 1'b1 && n < 100) begin
        n++;
        @(posedge clk);
        #1;
      end
      chk(n, (c == 7) ? 0 : (1 << c));
    end
    chk({ident_id_writable, ident_invalid_op}, 2'b01);
    // regions, region3 management space and guard
    wr(cfgc_pkg::IDX_CTRL_5, 8'h00);
    wr(cfgc_pkg::IDX_CTRL_2, 8'h00);
    wr(cfgc_pkg::IDX_CTRL_6, 8'h02);
    #1;
    chk({region_enable, alloc_line}, 9'h000);
    @(posedge clk);
    {region3_mgmt_space, region3_hit, acc_addr} <= {2'b11, 32'h0};
    #1;
    chk(region_enable, 8'h08);
    chk(region3_is_mgmt, 1'b1);
    chk(write_blocked, 1'b1);
    @(posedge clk);
    mgmt_active <= 1'b1;
    #1;
    chk(write_blocked, 1'b0);
    wr(cfgc_pkg::IDX_CTRL_6, 8'h43);
    pulse(2);
    rd(cfgc_pkg::IDX_CTRL_6, 8'h03);
    pulse(3);
    rd(cfgc_pkg::IDX_CTRL_6, 8'h43);
    // freeze: sticky, locks management bits outside the handler
    mgmt_active <= 1'b0;
    wr(cfgc_pkg::IDX_CTRL_3, 8'h11);
    chk(mgmt_bits_locked, 1'b1);
    wr(cfgc_pkg::IDX_CTRL_3, 8'h12);
    rd(cfgc_pkg::IDX_CTRL_3, 8'h11);
    wr(cfgc_pkg::IDX_CTRL_6, 8'h00);
    rd(cfgc_pkg::IDX_CTRL_6, 8'h41);
    mgmt_active <= 1'b1;
    wr(cfgc_pkg::IDX_CTRL_3, 8'h12);
    chk(mgmt_bits_locked, 1'b0);
    rd(cfgc_pkg::IDX_CTRL_3, 8'h13);
    mgmt_active <= 1'b0;
    do_reset();
    rd(cfgc_pkg::IDX_CTRL_3, 8'h00);
    // suspend pins: honoured only while enabled
    for (int e = 1; e >= 0; e--) begin
      wr(cfgc_pkg::IDX_CTRL_2, e ? 8'h80 : 8'h00);
      low_power_request_pin_n <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
      chk({low_power_state, low_power_ack_pin_oe}, {e[0], e[0]});
      if (e == 1) chk(low_power_ack_pin_n_o, 1'b0);
      low_power_request_pin_n <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      chk(low_power_state, 1'b0);
    end
    end_of_test();
  end
endmodule
